// ### hdl/tla_limit_alarm.sv
// Limit comparison, sticky flags, alarm latch and shutdown outputs of the
// temperature monitor, with its register file behind the pointer scheme.
// Assumes a serial slave engine on core_clk that issues byte strobes, and a
// converter on core_clk that reports results and a busy level.
`timescale 1ns/1ns
`include "tla_defs.svh"

module tla_limit_alarm
    import tla_pkg::*;
#(
    parameter int TIMEOUT_CYC = `TLA_TIMEOUT_MS * `TLA_CLK_KHZ,
    parameter logic [7:0] MAKER_CODE = 8'h5C,  // Arbitrary value
    parameter logic [7:0] REVISION   = 8'h01   // Arbitrary value
)(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire tla_req_t    reg_req,
    output logic [7:0]       rd_data_q,
    input  wire tla_result_t adc_result,
    input  wire logic        adc_busy,
    input  wire logic        ara_ack,
    input  wire logic        bus_open,
    input  wire logic        bus_activity,
    output logic             sda_release_q,
    output logic             oneshot_start_q,
    output logic             standby_q,
    output logic             ext_range_q,
    output logic [3:0]       conv_rate_q,
    output logic             pin6_o_q,
    output logic             pin6_oe_n_q,
    output logic             shutdown_o_q,
    output logic             shutdown_oe_n_q
);

    localparam logic [21:0] TIMEOUT_CNT = 22'(TIMEOUT_CYC);

    logic [7:0] ptr_q;
    logic [7:0] temp_q;
    logic [7:0] config_q;
    logic [7:0] high_q;
    logic [7:0] low_q;
    logic [7:0] sd_limit_q;
    logic [7:0] sd_hyst_q;
    logic [7:0] consec_q;
    logic [2:0] flt_cnt_q;
    logic       high_flag_q;
    logic       low_flag_q;
    logic       alarm_q;
    logic       sd_q;
    logic       sd2_q;
    logic [21:0] to_cnt_q;

    // Number of back-to-back faults needed; one more than the ones in the code
    function automatic logic [2:0] faults_needed(input logic [2:0] code);
        faults_needed = 3'(code[0]) + 3'(code[1]) + 3'(code[2]) + 3'h1;
    endfunction

    // Release point, clamped at zero so a large hysteresis cannot wrap
    function automatic logic [7:0] release_level(input logic [7:0] lim,
                                                 input logic [7:0] hyst);
        logic [8:0] diff;
        diff = {1'b0, lim} - {1'b0, hyst};
        release_level = diff[8] ? 8'h00 : diff[7:0];
    endfunction

    tla_pin6_t  pin6_mode;
    logic       wr_stb;
    logic       rd_stb;
    logic       status_rd;
    logic       high_now;
    logic       low_now;
    logic       res_high;
    logic       res_low;
    logic       res_out;
    logic [2:0] cnt_inc;
    logic       trip;
    logic [7:0] status_val;

    assign pin6_mode = config_q[`TLA_CFG_PIN6_BIT] ? TLA_PIN6_SHDN2 : TLA_PIN6_ALARM;
    assign wr_stb    = reg_req.wr;
    assign rd_stb    = reg_req.rd;
    assign status_rd = rd_stb && (ptr_q == `TLA_RD_STATUS);

    // Raw unsigned compares serve both formats; limits are never rescaled
    assign high_now = temp_q > high_q;
    assign low_now  = temp_q <= low_q;
    assign res_high = adc_result.value > high_q;
    assign res_low  = adc_result.value <= low_q;
    assign res_out  = res_high || res_low;
    assign cnt_inc  = (flt_cnt_q == 3'h4) ? 3'h4 : flt_cnt_q + 3'h1;
    assign trip     = adc_result.valid && res_out
                   && (cnt_inc >= faults_needed(
                          consec_q[`TLA_CONSEC_MSB:`TLA_CONSEC_LSB]));

    always_comb begin
        status_val = 8'h00;
        status_val[`TLA_ST_BUSY_BIT] = adc_busy;
        status_val[`TLA_ST_HIGH_BIT] = (pin6_mode == TLA_PIN6_SHDN2) ? sd2_q
                                                                     : high_flag_q;
        status_val[`TLA_ST_LOW_BIT]  = low_flag_q;
        status_val[`TLA_ST_SD_BIT]   = sd_q;
    end

    // Pointer: first byte of every write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= `TLA_RST_PTR;
        end else if (reg_req.ptr_load) begin
            ptr_q <= reg_req.data;
        end
    end

    // Writable registers; read-only addresses, status included, ignore data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_q   <= `TLA_RST_CONFIG;
            conv_rate_q <= 4'(`TLA_RST_RATE);
            high_q     <= `TLA_RST_HIGH;
            low_q      <= `TLA_RST_LOW;
            sd_limit_q <= `TLA_RST_SD_LIMIT;
            sd_hyst_q  <= `TLA_RST_SD_HYST;
            consec_q   <= `TLA_RST_CONSEC;
        end else if (wr_stb) begin
            unique case (ptr_q)
                `TLA_WR_CONFIG:   config_q    <= reg_req.data & `TLA_CFG_USED;
                `TLA_WR_RATE:     conv_rate_q <= reg_req.data[3:0];
                `TLA_WR_HIGH:     high_q      <= reg_req.data;
                `TLA_WR_LOW:      low_q       <= reg_req.data;
                `TLA_RW_SD_LIMIT: sd_limit_q  <= reg_req.data;
                `TLA_RW_SD_HYST:  sd_hyst_q   <= reg_req.data;
                `TLA_RW_CONSEC:   consec_q    <= reg_req.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby_q   <= 1'b0;
            ext_range_q <= 1'b0;
        end else begin
            standby_q   <= config_q[`TLA_CFG_STBY_BIT];
            ext_range_q <= config_q[`TLA_CFG_RANGE_BIT];
        end
    end

    // One conversion per write to 0x0F, standby only; data is dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oneshot_start_q <= 1'b0;
        end else begin
            oneshot_start_q <= wr_stb && (ptr_q == `TLA_WR_ONESHOT)
                            && config_q[`TLA_CFG_STBY_BIT];
        end
    end

    // Read data: status is sampled before its clear takes effect
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else if (rd_stb) begin
            unique case (ptr_q)
                `TLA_RD_TEMP:     rd_data_q <= temp_q;
                `TLA_RD_STATUS:   rd_data_q <= status_val;
                `TLA_RD_CONFIG:   rd_data_q <= config_q;
                `TLA_RD_RATE:     rd_data_q <= {4'h0, conv_rate_q};
                `TLA_RD_HIGH:     rd_data_q <= high_q;
                `TLA_RD_LOW:      rd_data_q <= low_q;
                `TLA_RW_SD_LIMIT: rd_data_q <= sd_limit_q;
                `TLA_RW_SD_HYST:  rd_data_q <= sd_hyst_q;
                `TLA_RW_CONSEC:   rd_data_q <= consec_q;
                `TLA_RD_MAKER:    rd_data_q <= MAKER_CODE;
                `TLA_RD_REVISION: rd_data_q <= REVISION;
                default:          rd_data_q <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_q <= `TLA_RST_TEMP;
        end else if (adc_result.valid) begin
            temp_q <= adc_result.value;
        end
    end

    // Any in-limit result restarts the filter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flt_cnt_q <= 3'h0;
        end else if (adc_result.valid) begin
            flt_cnt_q <= res_out ? cnt_inc : 3'h0;
        end
    end

    // Sticky fault flags, set only in alarm mode; there a new trip in the read cycle wins over the clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_flag_q <= 1'b0;
            low_flag_q  <= 1'b0;
        end else if (pin6_mode == TLA_PIN6_ALARM) begin
            if (trip && res_high) begin
                high_flag_q <= 1'b1;
            end else if (status_rd && !high_now) begin
                high_flag_q <= 1'b0;
            end
            if (trip && res_low) begin
                low_flag_q <= 1'b1;
            end else if (status_rd && !low_now) begin
                low_flag_q <= 1'b0;
            end
        end else begin
            high_flag_q <= 1'b0;
            if (status_rd && !low_now) begin
                low_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q <= 1'b0;
        end else if (pin6_mode == TLA_PIN6_ALARM && trip) begin
            alarm_q <= 1'b1;
        end else if ((status_rd || ara_ack) && !high_now && !low_now) begin
            alarm_q <= 1'b0;
        end
    end

    // Shutdown comparators follow the stored result and live limits, so
    // register changes in standby still move the pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_q <= 1'b0;
        end else if (temp_q > sd_limit_q) begin
            sd_q <= 1'b1;
        end else if (temp_q <= release_level(sd_limit_q, sd_hyst_q)) begin
            sd_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sd2_q <= 1'b0;
        end else if (pin6_mode != TLA_PIN6_SHDN2) begin
            sd2_q <= 1'b0;
        end else if (high_now) begin
            sd2_q <= 1'b1;
        end else if (temp_q <= release_level(high_q, sd_hyst_q)) begin
            sd2_q <= 1'b0;
        end
    end

    // Open drain: data always low, enable low means pulling the pin down
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin6_o_q        <= 1'b0;
            pin6_oe_n_q     <= 1'b1;
            shutdown_o_q    <= 1'b0;
            shutdown_oe_n_q <= 1'b1;
        end else begin
            pin6_o_q        <= 1'b0;
            shutdown_o_q    <= 1'b0;
            shutdown_oe_n_q <= !sd_q;
            unique case (pin6_mode)
                TLA_PIN6_SHDN2: pin6_oe_n_q <= !sd2_q;
                default:        pin6_oe_n_q <= !(alarm_q
                                    && !config_q[`TLA_CFG_MASK_BIT]);
            endcase
        end
    end

    // Bus timeout: idle time inside an open transaction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            to_cnt_q      <= 22'h000000;
            sda_release_q <= 1'b0;
        end else if (!consec_q[`TLA_CONSEC_TO_BIT] || !bus_open || bus_activity) begin
            to_cnt_q      <= 22'h000000;
            sda_release_q <= 1'b0;
        end else if (to_cnt_q == TIMEOUT_CNT - 22'h000001) begin
            to_cnt_q      <= to_cnt_q + 22'h000001;
            sda_release_q <= 1'b1;
        end else begin
            sda_release_q <= 1'b0;
            if (to_cnt_q != TIMEOUT_CNT) begin
                to_cnt_q <= to_cnt_q + 22'h000001;
            end
        end
    end

endmodule

// ### include/tla_defs.svh
// Offsets, field positions, reset values and timing counts of the limit alarm.
// Included by the design; definitions only.
`ifndef TLA_DEFS_SVH
`define TLA_DEFS_SVH

`define TLA_RD_TEMP        8'h00
`define TLA_RD_STATUS      8'h02
`define TLA_RD_CONFIG      8'h03
`define TLA_RD_RATE        8'h04
`define TLA_RD_HIGH        8'h05
`define TLA_RD_LOW         8'h06
`define TLA_WR_CONFIG      8'h09
`define TLA_WR_RATE        8'h0A
`define TLA_WR_HIGH        8'h0B
`define TLA_WR_LOW         8'h0C
`define TLA_WR_ONESHOT     8'h0F
`define TLA_RW_SD_LIMIT    8'h20
`define TLA_RW_SD_HYST     8'h21
`define TLA_RW_CONSEC      8'h22
`define TLA_RD_MAKER       8'hFE
`define TLA_RD_REVISION    8'hFF

`define TLA_RST_TEMP       8'h00
`define TLA_RST_CONFIG     8'h00
`define TLA_RST_RATE       8'h08
`define TLA_RST_HIGH       8'h55
`define TLA_RST_LOW        8'h00
`define TLA_RST_SD_LIMIT   8'h55
`define TLA_RST_SD_HYST    8'h0A
`define TLA_RST_CONSEC     8'h01
`define TLA_RST_PTR        8'h00

`define TLA_CFG_MASK_BIT   7
`define TLA_CFG_STBY_BIT   6
`define TLA_CFG_PIN6_BIT   5
`define TLA_CFG_RANGE_BIT  2
`define TLA_CFG_USED       8'hE4
`define TLA_RATE_USED      8'h0F
`define TLA_CONSEC_TO_BIT  7
`define TLA_CONSEC_LSB     1
`define TLA_CONSEC_MSB     3
`define TLA_ST_BUSY_BIT    7
`define TLA_ST_HIGH_BIT    6
`define TLA_ST_LOW_BIT     5
`define TLA_ST_SD_BIT      0

`define TLA_TIMEOUT_MS     25
`define TLA_CLK_KHZ        100000

`endif

// ### include/tla_pkg.sv
// Types shared by the temperature limit alarm.
// Assumes tla_defs.svh on the include path.
package tla_pkg;

    // Byte access from the serial engine, one strobe per cycle at most
    typedef struct packed {
        logic       ptr_load;
        logic       wr;
        logic       rd;
        logic [7:0] data;
    } tla_req_t;

    // Pin six as driven by the alarm logic
    typedef enum logic [1:0] {
        TLA_PIN6_ALARM = 2'b01,
        TLA_PIN6_SHDN2 = 2'b10
    } tla_pin6_t;

    // New measurement from the converter
    typedef struct packed {
        logic       valid;
        logic [7:0] value;
    } tla_result_t;

endpackage

// ### verification/tla_host.sv
// Host model: register access through pointer, write and read strobes.
// Assumes the alarm block samples strobes on the rising core_clk edge.
`timescale 1ns/1ns
module tla_host
    import tla_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [7:0] rd_data_q,
    output tla_req_t        reg_req
);
    initial reg_req = '0;

    // Idle data is inverted so a stale byte is never mistaken for fresh
    task automatic put(input logic p, w, r, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = {p, w, r, d};
        @(negedge core_clk);
        reg_req = {3'b000, ~d};
    endtask

    // Writable registers are reached only through their write addresses
    task automatic wr(input logic [7:0] a, d);
        put(1'b1, 1'b0, 1'b0, a);
        put(1'b0, 1'b1, 1'b0, d);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        put(1'b1, 1'b0, 1'b0, a);
        put(1'b0, 1'b0, 1'b1, 8'h00);
        @(negedge core_clk);
        d = rd_data_q;
    endtask
endmodule

// ### verification/tla_limit_alarm_assertions.sv
// Port checker for the limit alarm, bound into the design.
// Assumes pointer and configuration change only through register strobes.
`timescale 1ns/1ns
module tla_limit_alarm_assertions
    import tla_pkg::*;
#(
    parameter int TIMEOUT_CYC = 50
)(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire tla_req_t    reg_req,
    input wire logic [7:0]  rd_data_q,
    input wire tla_result_t adc_result,
    input wire logic        adc_busy,
    input wire logic        ara_ack,
    input wire logic        bus_open,
    input wire logic        bus_activity,
    input wire logic        sda_release_q,
    input wire logic        oneshot_start_q,
    input wire logic        standby_q,
    input wire logic        ext_range_q,
    input wire logic [3:0]  conv_rate_q,
    input wire logic        pin6_o_q,
    input wire logic        pin6_oe_n_q,
    input wire logic        shutdown_o_q,
    input wire logic        shutdown_oe_n_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] ptr_q;
    logic [7:0] cfg_q;
    int         idle_q;
    wire        st_rd  = reg_req.rd && ptr_q == 8'h02;
    wire        clr_ev = st_rd || ara_ack;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) ptr_q <= 8'h00;
        else if (reg_req.ptr_load) ptr_q <= reg_req.data;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) cfg_q <= 8'h00;
        else if (reg_req.wr && ptr_q == 8'h09) cfg_q <= reg_req.data & 8'hE4;
    end

    // Idle span of an open transaction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) idle_q <= 0;
        else if (!bus_open || bus_activity) idle_q <= 0;
        else idle_q <= idle_q + 1;
    end

    // Pin edges caused by a mode change are not judged
    sequence s_cfg_held;
        $stable(cfg_q) ##1 $stable(cfg_q);
    endsequence

    a_oneshot_pulse: assert property (oneshot_start_q |=> !oneshot_start_q)
        else $error("one-shot start longer than a cycle");
    a_oneshot_cause: assert property (oneshot_start_q |->
        $past(reg_req.wr) && $past(ptr_q) == 8'h0F && $past(standby_q))
        else $error("one-shot start without standby trigger write");
    a_busy_bit: assert property (st_rd |=> rd_data_q[7] == $past(adc_busy))
        else $error("status busy bit wrong");
    a_standby_range: assert property ($stable(cfg_q) |->
        standby_q == cfg_q[6] && ext_range_q == cfg_q[2])
        else $error("standby or range level differs from configuration");
    a_mask_alarm: assert property (cfg_q[7] && !cfg_q[5] &&
        $past(cfg_q[7] && !cfg_q[5]) |-> pin6_oe_n_q)
        else $error("masked alarm pin driven");
    a_alarm_cause: assert property (s_cfg_held ##0 $fell(pin6_oe_n_q) |->
        $past(adc_result.valid, 2) || $past(adc_result.valid, 3))
        else $error("pin six asserted without a result");
    a_latch_release: assert property (s_cfg_held ##0 (!cfg_q[5] && $rose(pin6_oe_n_q)) |->
        $past(clr_ev, 2) || $past(clr_ev, 3))
        else $error("alarm released without status read or alert response");
    a_shut_cause: assert property ($fell(shutdown_oe_n_q) |->
        $past(adc_result.valid, 3) || $past(adc_result.valid, 4))
        else $error("shutdown asserted without a result");
    a_timeout_wait: assert property (sda_release_q |-> idle_q >= TIMEOUT_CYC - 2)
        else $error("data line released before timeout");
endmodule

bind tla_limit_alarm tla_limit_alarm_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .reg_req         (reg_req),
    .rd_data_q       (rd_data_q),
    .adc_result      (adc_result),
    .adc_busy        (adc_busy),
    .ara_ack         (ara_ack),
    .bus_open        (bus_open),
    .bus_activity    (bus_activity),
    .sda_release_q   (sda_release_q),
    .oneshot_start_q (oneshot_start_q),
    .standby_q       (standby_q),
    .ext_range_q     (ext_range_q),
    .conv_rate_q     (conv_rate_q),
    .pin6_o_q        (pin6_o_q),
    .pin6_oe_n_q     (pin6_oe_n_q),
    .shutdown_o_q    (shutdown_o_q),
    .shutdown_oe_n_q (shutdown_oe_n_q)
);

// ### verification/temperature_limit_alarm_tb_top.sv
// Self-checking bench for the limit alarm with the host model.
// Assumes results and side inputs are driven on falling edges.
`timescale 1ns/1ns
module temperature_limit_alarm_tb_top
    import tla_pkg::*;
;
    localparam int TO = 40;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    tla_req_t    req;
    tla_result_t res      = '0;
    logic        busy     = 1'b0;
    logic        ara      = 1'b0;
    logic        b_open   = 1'b0;
    logic        b_act    = 1'b0;
    logic [7:0]  rdat;
    logic [7:0]  v;
    logic [3:0]  rate;
    logic        sda, osh, stby, xr, p6o, p6n, sdo, sdn;
    int          n_fail = 0;
    int          tests_run = 0;
    int          n_osh = 0;
    int          n_sda = 0;
    int          k;
    logic [7:0]  ra [12] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h20, 8'h21, 8'h22,
                             8'hFE, 8'hFF, 8'h0F, 8'h07};
    logic [7:0]  rv [12] = '{8'h00, 8'h00, 8'h08, 8'h55, 8'h00, 8'h55, 8'h0A, 8'h01,
                             8'h3C, 8'h02, 8'h00, 8'h00};
    logic [7:0]  cc [4]  = '{8'h00, 8'h02, 8'h06, 8'h0E};

    tla_host i_host (.core_clk(core_clk), .rd_data_q(rdat), .reg_req(req));

    // Maker and revision codes are arbitrary
    tla_limit_alarm #(.TIMEOUT_CYC(TO), .MAKER_CODE(8'h3C), .REVISION(8'h02)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_req(req), .rd_data_q(rdat),
        .adc_result(res), .adc_busy(busy), .ara_ack(ara), .bus_open(b_open),
        .bus_activity(b_act), .sda_release_q(sda), .oneshot_start_q(osh),
        .standby_q(stby), .ext_range_q(xr), .conv_rate_q(rate), .pin6_o_q(p6o),
        .pin6_oe_n_q(p6n), .shutdown_o_q(sdo), .shutdown_oe_n_q(sdn));

    initial forever #5 core_clk = ~core_clk;

    always @(negedge core_clk) begin
        if (osh) n_osh++;
        if (sda) n_sda++;
    end

    task automatic chk(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, exp);
        i_host.rd(a, v);
        chk(v, exp);
    endtask

    task automatic temp(input logic [7:0] t);
        @(negedge core_clk);
        res = {1'b1, t};
        @(negedge core_clk);
        res = {1'b0, ~t};
        repeat (5) @(negedge core_clk);
    endtask

    // Expected pin six and shutdown enables, low means pulled low;
    // open-drain data lines must always sit low
    task automatic pins(input logic [1:0] exp);
        repeat (2) @(negedge core_clk);
        chk({4'h0, p6o, sdo, p6n, sdn}, {6'h00, exp});
    endtask

    task automatic ara_hit;
        @(negedge core_clk);
        ara = 1'b1;
        @(negedge core_clk);
        ara = 1'b0;
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // A full run needs well under 6000 cycles
    initial begin
        #200000;
        n_fail++;
        wrap_up;
    end

    initial begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        for (k = 0; k < 12; k++) rchk(ra[k], rv[k]);
        i_host.wr(8'h05, 8'h11);
        rchk(8'h05, 8'h55);
        i_host.wr(8'h0B, 8'h40);
        i_host.wr(8'h0C, 8'h10);
        rchk(8'h05, 8'h40);
        i_host.wr(8'h02, 8'hFF);
        busy = 1'b1;
        rchk(8'h02, 8'h80);
        busy = 1'b0;
        temp(8'h40);
        pins(2'b11);
        temp(8'h41);
        pins(2'b01);
        temp(8'h20);
        rchk(8'h02, 8'h40);
        pins(2'b11);
        rchk(8'h02, 8'h00);
        temp(8'h10);
        rchk(8'h02, 8'h20);
        rchk(8'h02, 8'h20);
        pins(2'b01);
        temp(8'h30);
        rchk(8'h02, 8'h20);
        rchk(8'h02, 8'h00);
        temp(8'h41);
        ara_hit;
        pins(2'b01);
        temp(8'h30);
        ara_hit;
        pins(2'b11);
        rchk(8'h02, 8'h40);
        i_host.wr(8'h09, 8'h80);
        temp(8'h41);
        pins(2'b11);
        temp(8'h30);
        rchk(8'h02, 8'h40);
        i_host.wr(8'h09, 8'h00);
        for (k = 0; k < 4; k++) begin
            i_host.wr(8'h22, cc[k]);
            repeat (k) temp(8'h41);
            temp(8'h30);
            repeat (k) temp(8'h41);
            pins(2'b11);
            temp(8'h41);
            pins(2'b01);
            temp(8'h30);
            rchk(8'h02, 8'h40);
        end
        i_host.wr(8'h0B, 8'h70);
        temp(8'h55);
        pins(2'b11);
        temp(8'h56);
        pins(2'b10);
        rchk(8'h02, 8'h01);
        temp(8'h4C);
        pins(2'b10);
        temp(8'h4B);
        pins(2'b11);
        rchk(8'h02, 8'h00);
        i_host.wr(8'h21, 8'h05);
        rchk(8'h21, 8'h05);
        i_host.wr(8'h0A, 8'hF3);
        rchk(8'h04, 8'h03);
        chk({4'h0, rate}, 8'h03);
        temp(8'h56);
        temp(8'h50);
        pins(2'b11);
        i_host.wr(8'h0F, 8'hAA);
        i_host.wr(8'h09, 8'h44);
        i_host.wr(8'h0F, 8'h5A);
        repeat (3) @(negedge core_clk);
        chk(n_osh[7:0], 8'h01);
        chk({6'h00, stby, xr}, 8'h03);
        rchk(8'h03, 8'h44);
        rchk(8'h05, 8'h70);
        rchk(8'h0F, 8'h00);
        temp(8'h56);
        pins(2'b10);
        temp(8'h30);
        // Raise the main shutdown limit so only pin six moves below
        i_host.wr(8'h20, 8'h7F);
        rchk(8'h20, 8'h7F);
        i_host.wr(8'h09, 8'hE0);
        temp(8'h05);
        pins(2'b11);
        temp(8'h71);
        pins(2'b01);
        rchk(8'h02, 8'h40);
        temp(8'h6C);
        pins(2'b01);
        temp(8'h6B);
        pins(2'b11);
        i_host.wr(8'h22, 8'h80);
        b_open = 1'b1;
        repeat (TO - 10) @(negedge core_clk);
        b_act = 1'b1;
        @(negedge core_clk);
        b_act = 1'b0;
        repeat (TO - 5) @(negedge core_clk);
        chk(n_sda[7:0], 8'h00);
        repeat (15) @(negedge core_clk);
        chk(n_sda[7:0], 8'h01);
        b_open = 1'b0;
        wrap_up;
    end
endmodule
